// ==== desc_check_pkg.sv ====
// shared constants and carriers for the long-mode descriptor checker
package desc_check_pkg;
	localparam logic [3:0] TY_ILL0 = 4'h0;
	localparam logic [3:0] TY_ILL1 = 4'h1;
	localparam logic [3:0] TY_LOCAL = 4'h2;
	localparam logic [3:0] TY_ILL3 = 4'h3;
	localparam logic [3:0] TY_TASK_AVAIL = 4'h9;
	localparam logic [3:0] TY_TASK_BUSY = 4'hB;
	localparam logic [3:0] TY_CALL = 4'hC;
	localparam logic [3:0] TY_ILLD = 4'hD;
	localparam logic [3:0] TY_INTR = 4'hE;
	localparam logic [3:0] TY_TRAP = 4'hF;
	localparam logic [3:0] TY_LEG_LO = 4'h4;
	localparam logic [3:0] TY_LEG_HI = 4'h7;
	// field positions inside the 128-bit expanded descriptor
	localparam int TYPE_LSB = 40;
	localparam int S_BIT = 44;
	localparam int UPPER_LSB = 104;
	localparam int UPPER_MSB = 108;
	localparam int IDX_LSB = 32;
	localparam int LIM_HI_LSB = 48;
	localparam int GRAN_BIT = 55;
	localparam int SEL_LSB = 16;
	localparam int VA_BITS = 48;
	localparam int VEC_SHIFT = 4;
	// register offsets
	localparam logic [3:0] A_CTRL = 4'h0;
	localparam logic [3:0] A_D0 = 4'h1;
	localparam logic [3:0] A_D1 = 4'h2;
	localparam logic [3:0] A_D2 = 4'h3;
	localparam logic [3:0] A_D3 = 4'h4;
	localparam logic [3:0] A_AUX = 4'h5;
	localparam logic [3:0] A_STAT = 4'h6;
	localparam logic [3:0] A_OFF_LO = 4'h7;
	localparam logic [3:0] A_OFF_HI = 4'h8;
	localparam logic [3:0] A_VTA_LO = 4'h9;
	localparam logic [3:0] A_VTA_HI = 4'hA;
	localparam logic [3:0] A_VTB_LO = 4'hB;
	localparam logic [3:0] A_VTB_HI = 4'hC;
	localparam logic [3:0] A_LIMIT = 4'hD;
	localparam logic [31:0] BAD_ADDR = 32'hDEAD_0000;
	typedef enum logic [1:0] {K_SYSTEM, K_GATE, K_LEGACY} kind_e;
	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} bus_req_s;
	typedef struct packed {
		logic fault;
		logic [15:0] code;
		logic [2:0] stack_index;
		logic stack_switch;
		logic [3:0] dtype;
		logic done;
	} result_s;
endpackage

// ==== desc_check.sv ====
// long-mode system and gate descriptor checker with register port
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/100ps
module desc_check
	import desc_check_pkg::*;
#(
	parameter int VA_W = VA_BITS
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [3:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	output logic FAULT,
	output logic [15:0] FAULT_CODE,
	output logic DONE
);
	// ctrl: [0] go, [2:1] kind, [3] long mode, [4] 64-bit sub-mode,
	// [5] target cs long flag, [6] target cs default-size flag
	// aux: [15:0] selector, [23:16] vector, [31:24] access offset
	localparam int C_GO = 0;
	localparam int C_KIND = 1;
	localparam int C_LONG = 3;
	localparam int C_SUB64 = 4;
	localparam int C_CSL = 5;
	localparam int C_CSD = 6;
	localparam int X_VEC = 16;
	localparam int X_OFS = 24;
	localparam logic [31:0] LIM_ONE = 32'h0000_0001;

	typedef struct packed {
		logic [1:0] rst_sync;
		logic [6:0] ctrl;
		logic [127:0] desc;
		logic [31:0] aux;
		result_s res;
		logic [63:0] offset;
		logic [63:0] vt_addr;
		logic [63:0] vt_base;
		logic [31:0] limit;
		logic [31:0] rdata;
	} state_s;

	state_s q, d;
	logic rst_n_int;
	bus_req_s bus;
	logic [1:0] rs_q;

	function automatic logic canonical(input logic [63:0] a);
		logic [63:0] ext;
		ext = {{(64 - VA_W){a[VA_W-1]}}, a[VA_W-1:0]};
		return ext == a;
	endfunction

	function automatic logic is_legacy_gate(input logic [3:0] t);
		return t >= TY_LEG_LO && t <= TY_LEG_HI;
	endfunction

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			rs_q <= 2'h0;
		else
			rs_q <= {rs_q[0], 1'b1};
	end
	assign rst_n_int = rs_q[1];
	assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

	always_comb begin
		logic [3:0] ty;
		logic long_m;
		logic wide;
		logic [63:0] base;
		logic [31:0] lim;
		logic up_zero;
		logic bad;
		logic [15:0] code;
		kind_e kind;
		d = q;
		d.rst_sync = 2'h0;
		d.res.done = 1'b0;
		ty = q.desc[TYPE_LSB +: 4];
		long_m = q.ctrl[C_LONG];
		kind = kind_e'(q.ctrl[C_KIND +: 2]);
		up_zero = q.desc[UPPER_MSB:UPPER_LSB] == 5'h00;
		bad = 1'b0;
		code = 16'h0000;
		base = 64'h0;
		lim = 32'h0;
		wide = 1'b0;
		if (bus.wr) begin
			if (bus.addr == A_CTRL)
				d.ctrl = bus.wdata[6:0];
			else if (bus.addr == A_D0)
				d.desc[31:0] = bus.wdata;
			else if (bus.addr == A_D1)
				d.desc[63:32] = bus.wdata;
			else if (bus.addr == A_D2)
				d.desc[95:64] = bus.wdata;
			else if (bus.addr == A_D3)
				d.desc[127:96] = bus.wdata;
			else if (bus.addr == A_AUX)
				d.aux = bus.wdata;
			else if (bus.addr == A_VTB_LO)
				d.vt_base[31:0] = bus.wdata;
			else if (bus.addr == A_VTB_HI)
				d.vt_base[63:32] = bus.wdata;
		end
		if (q.ctrl[C_GO]) begin
			// a go written in this very cycle must survive the clear
			if (!(bus.wr && bus.addr == A_CTRL))
				d.ctrl[C_GO] = 1'b0;
			d.res.done = 1'b1;
			d.res.dtype = ty;
			d.res.stack_index = 3'h0;
			d.res.stack_switch = 1'b0;
			// system descriptors are expanded only in 64-bit sub-mode
			wide = long_m && q.ctrl[C_SUB64];
			if (kind == K_GATE && long_m) begin
				// gates are always 128 bits wide in long mode
				d.offset = {q.desc[95:64], q.desc[63:48], q.desc[15:0]};
				if (q.desc[S_BIT] || is_legacy_gate(ty) ||
						!(ty == TY_CALL || ty == TY_INTR ||
						ty == TY_TRAP)) begin
					bad = 1'b1;
					code = q.aux[15:0];
				end else if (!canonical(d.offset)) begin
					bad = 1'b1;
					code = 16'h0000;
				end else if (!q.ctrl[C_CSL] || q.ctrl[C_CSD]) begin
					bad = 1'b1;
					if (ty == TY_CALL)
						code = q.desc[SEL_LSB +: 16];
					else
						code = {8'h00, q.aux[X_VEC +: 8]};
				end else if (ty != TY_CALL) begin
					// count field of call gates is never read
					d.res.stack_index = q.desc[IDX_LSB +: 3];
					d.res.stack_switch = q.desc[IDX_LSB +: 3] == 3'h0;
					d.vt_addr = q.vt_base +
						{52'h0, q.aux[X_VEC +: 8], 4'h0};
				end
			end else if (kind == K_SYSTEM) begin
				if (q.desc[S_BIT] || ty == TY_ILL0 || ty == TY_ILL1 ||
						ty == TY_ILL3 || ty == TY_ILLD ||
						(long_m && !(ty == TY_LOCAL ||
						ty == TY_TASK_AVAIL ||
						ty == TY_TASK_BUSY))) begin
					bad = 1'b1;
					code = q.aux[15:0];
				end else begin
					base = {32'h0, q.desc[63:56], q.desc[39:16]};
					if (wide) begin
						base[63:32] = q.desc[95:64];
						if (!up_zero || !canonical(base)) begin
							bad = 1'b1;
							code = q.aux[15:0];
						end
					end
					lim = {12'h000, q.desc[LIM_HI_LSB +: 4],
						q.desc[15:0]};
					if (q.desc[GRAN_BIT])
						lim = {lim[19:0], 12'hFFF};
					d.limit = lim;
					// access at offset must fit inside the limit
					if (!bad && ({24'h0, q.aux[X_OFS +: 8]} > lim)) begin
						bad = 1'b1;
						code = q.aux[15:0];
					end
				end
			end else begin
				// high dword of an upper half read as a legacy descriptor;
				// zero S and type is always illegal there
				if (!q.desc[S_BIT] && (ty == TY_ILL0 ||
						(long_m && is_legacy_gate(ty)))) begin
					bad = 1'b1;
					code = q.aux[15:0];
				end
			end
			d.res.fault = bad;
			d.res.code = code;
		end
		d.rdata = 32'h0000_0000;
		if (bus.rd) begin
			if (bus.addr == A_CTRL)
				d.rdata = {25'h0, q.ctrl};
			else if (bus.addr == A_D0)
				d.rdata = q.desc[31:0];
			else if (bus.addr == A_D1)
				d.rdata = q.desc[63:32];
			else if (bus.addr == A_D2)
				d.rdata = q.desc[95:64];
			else if (bus.addr == A_D3)
				d.rdata = q.desc[127:96];
			else if (bus.addr == A_AUX)
				d.rdata = q.aux;
			else if (bus.addr == A_STAT)
				d.rdata = {q.res.dtype, q.res.stack_switch,
					q.res.stack_index, 7'h00, q.res.fault, q.res.code};
			else if (bus.addr == A_OFF_LO)
				d.rdata = q.offset[31:0];
			else if (bus.addr == A_OFF_HI)
				d.rdata = q.offset[63:32];
			else if (bus.addr == A_VTA_LO)
				d.rdata = q.vt_addr[31:0];
			else if (bus.addr == A_VTA_HI)
				d.rdata = q.vt_addr[63:32];
			else if (bus.addr == A_VTB_LO)
				d.rdata = q.vt_base[31:0];
			else if (bus.addr == A_VTB_HI)
				d.rdata = q.vt_base[63:32];
			else if (bus.addr == A_LIMIT)
				d.rdata = q.limit;
			else
				d.rdata = BAD_ADDR;
		end
	end

	always_ff @(posedge CLK or negedge rst_n_int) begin
		if (!rst_n_int)
			q <= '0;
		else
			q <= d;
	end

	assign RDATA = q.rdata;
	assign FAULT = q.res.fault;
	assign FAULT_CODE = q.res.code;
	assign DONE = q.res.done;
endmodule

// ==== desc_check_monitor.sv ====
// port-level assertions for the descriptor checker
`timescale 1ns/100ps
module desc_check_monitor
	import desc_check_pkg::*;
#(parameter int VA_W = VA_BITS) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [3:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [31:0] RDATA,
	input wire logic FAULT,
	input wire logic [15:0] FAULT_CODE,
	input wire logic DONE
);
	logic [31:0] d1_q, d2_q, aux_q;
	logic [63:0] off;
	logic [3:0] ty;
	logic go, gate, sys, sys_ill, ncan, cs_ok, ief;
	// shadows of what software wrote, no reset needed: written before go
	always_ff @(posedge CLK) begin
		if (WR && ADDR == A_D1) d1_q <= WDATA;
		if (WR && ADDR == A_D2) d2_q <= WDATA;
		if (WR && ADDR == A_AUX) aux_q <= WDATA;
	end
	assign go = WR && ADDR == A_CTRL && WDATA[0];
	assign gate = go && WDATA[2:1] == 2'h1 && WDATA[3];
	// limit faults carry the same selector code, but keep them out anyway
	assign sys = go && WDATA[2:1] == 2'h0 && WDATA[3] && aux_q[31:24] == 8'h0;
	assign ty = d1_q[11:8];
	assign sys_ill = ty == TY_ILL0 || ty == TY_ILL1 || ty == TY_ILL3 ||
		ty == TY_ILLD;
	assign off = {d2_q, 32'h0};
	assign ncan = |off[63:VA_W-1] && !(&off[63:VA_W-1]);
	assign cs_ok = WDATA[6:5] == 2'h1;
	assign ief = ty == TY_INTR || ty == TY_TRAP;
	sequence check_end;
		##1 !DONE ##1 DONE ##1 !DONE;
	endsequence
	sequence fault_sel;
		##2 DONE && FAULT && FAULT_CODE == aux_q[15:0];
	endsequence
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	done_pulse_a: assert property (go |-> check_end)
		else $error("check done pulse misplaced");
	sys_type_a: assert property (sys && sys_ill |-> fault_sel)
		else $error("illegal system type not faulted");
	gate_type_a: assert property (gate && ty >= TY_LEG_LO &&
		ty <= TY_LEG_HI |-> fault_sel)
		else $error("illegal gate type not faulted");
	gate_offset_a: assert property (gate && ief && cs_ok && ncan
		|-> ##2 FAULT && FAULT_CODE == 16'h0)
		else $error("non-canonical offset code wrong");
	intr_target_a: assert property (gate && ief && !ncan && !cs_ok
		|-> ##2 FAULT && FAULT_CODE == {8'h0, aux_q[23:16]})
		else $error("bad target code not vector");
	good_gate_a: assert property (gate && ief && !ncan && cs_ok
		|-> ##2 !FAULT)
		else $error("good gate faulted");
	result_hold_a: assert property (!DONE |->
		$stable(FAULT) && $stable(FAULT_CODE))
		else $error("result changed without done");
	read_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0)
		else $error("read data not zero when idle");
	unmapped_rd_a: assert property (RD && ADDR == 4'hE |=> RDATA == BAD_ADDR)
		else $error("unmapped read value wrong");
endmodule
bind desc_check desc_check_monitor #(.VA_W(VA_W)) mon_u (.CLK(CLK),
	.RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
	.RDATA(RDATA), .FAULT(FAULT), .FAULT_CODE(FAULT_CODE), .DONE(DONE));

// ==== long_mode_descriptor_check_tb.sv ====
// self-checking bench for the descriptor checker
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
	fails++; $display("unexpected %s exp %h got %h", nm, ex, got); end end
module long_mode_descriptor_check_tb;
	import desc_check_pkg::*;
	localparam logic [31:0] AUX = 32'h0021_0123;
	logic CLK = 0, RST_N = 0, WR = 0, RD = 0, FAULT, DONE;
	logic [3:0] ADDR = 4'h0;
	logic [31:0] WDATA = 32'h0, RDATA, rv;
	logic [15:0] FAULT_CODE;
	int fails = 0, n_compared = 0, cyc = 0;
	always #25 CLK = ~CLK;
	desc_check #(.VA_W(48)) dut_u (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR),
		.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .FAULT(FAULT),
		.FAULT_CODE(FAULT_CODE), .DONE(DONE));
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge CLK);
		WR <= 1'h1;
		ADDR <= a;
		WDATA <= d;
		@(posedge CLK);
		WR <= 1'h0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge CLK);
		RD <= 1'h1;
		ADDR <= a;
		@(posedge CLK);
		RD <= 1'h0;
		#1 rv = RDATA;
	endtask
	task automatic desc(input logic [31:0] d0, d1, d2, aux);
		wr(A_D0, d0);
		wr(A_D1, d1);
		wr(A_D2, d2);
		wr(A_D3, 32'h0);
		wr(A_AUX, aux);
	endtask
	task automatic run(input logic [31:0] c, input logic f);
		wr(A_CTRL, c);
		@(posedge CLK);
		#1 `CHK("done", 1'h1, DONE)
		`CHK("fault", f, FAULT)
	endtask
	task automatic t_sys();
		logic [3:0] ty [7] = '{4'h0, 4'h1, 4'h3, 4'hD, 4'h2, 4'h9, 4'hB};
		for (int i = 0; i < 7; i++) begin
			desc(32'h0, {20'h0, ty[i], 8'h0}, 32'h0, AUX);
			run(32'h39, i < 4);
			if (i < 4) `CHK("code", 16'h0123, FAULT_CODE)
		end
		desc(32'hF, 32'h900, 32'h0, 32'h1021_0123);
		run(32'h39, 1'h1);
		desc(32'hF, 32'h0080_0900, 32'h0, 32'h1021_0123);
		run(32'h39, 1'h0);
		rd(A_LIMIT);
		`CHK("limit", 32'h0000_FFFF, rv)
		desc(32'h0, 32'h900, 32'h0001_0000, AUX);
		run(32'h29, 1'h0);
		desc(32'h0, 32'h900, 32'h0001_0000, AUX);
		run(32'h39, 1'h1);
		`CHK("code", 16'h0123, FAULT_CODE)
		$display("system test done");
	endtask
	task automatic t_gate();
		logic [3:0] ty [3] = '{TY_CALL, TY_INTR, TY_TRAP};
		wr(A_VTB_LO, 32'h1000_0000);
		wr(A_VTB_HI, 32'h0);
		for (int i = 0; i < 3; i++) begin
			// call gates keep their count field zero
			desc(32'h4567_0000, {16'h0, 4'h8, ty[i], (i > 0 ? 8'h3 : 8'h0)},
				32'h0, AUX);
			run(32'h2B, 1'h0);
			rd(A_STAT);
			if (i > 0) `CHK("stack", 4'h3, rv[27:24])
		end
		rd(A_VTA_LO);
		`CHK("vector addr", 32'h1000_0210, rv)
		desc(32'h4567_0000, {16'h0, 4'h8, TY_INTR, 8'h0}, 32'h0, AUX);
		run(32'h2B, 1'h0);
		rd(A_STAT);
		`CHK("stack", 4'h8, rv[27:24])
		for (int t = 4; t < 8; t++) begin
			desc(32'h0, {16'h0, 4'h8, t[3:0], 8'h0}, 32'h0, AUX);
			run(32'h3B, 1'h1);
			`CHK("code", 16'h0123, FAULT_CODE)
		end
		desc(32'h4567_0000, {16'h0, 4'h8, TY_CALL, 8'h0}, 32'h0, AUX);
		run(32'h6B, 1'h1);
		`CHK("code", 16'h4567, FAULT_CODE)
		desc(32'h4567_0000, {16'h0, 4'h8, TY_INTR, 8'h0}, 32'h0, AUX);
		run(32'h0B, 1'h1);
		`CHK("code", 16'h0021, FAULT_CODE)
		desc(32'h4567_0000, {16'h0, 4'h8, TY_INTR, 8'h0}, 32'h8000, AUX);
		run(32'h2B, 1'h1);
		`CHK("code", 16'h0, FAULT_CODE)
		rd(A_OFF_HI);
		`CHK("offset hi", 32'h0000_8000, rv)
		$display("gate test done");
	endtask
	task automatic t_misc();
		desc(32'h0, 32'h0, 32'h0, AUX);
		run(32'h1D, 1'h1);
		rd(4'hE);
		`CHK("unmapped", BAD_ADDR, rv)
		$display("misc test done");
	endtask
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// the whole run needs well under a thousand cycles
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			final_report();
		end
	end
	initial begin
		repeat (6) @(posedge CLK);
		RST_N <= 1'h1;
		repeat (3) @(posedge CLK);
		t_sys();
		t_gate();
		t_misc();
		final_report();
	end
endmodule
